/* src/dsd_pkg.sv */
// package: register map, field positions, timing and carrier types for the drive status display
package dsd_pkg;

  // ==========================================================
  // register map (byte addresses)
  localparam logic [11:0] DSD_STATE_WORD_ADDR = 12'h040;
  localparam logic [11:0] DSD_INT_STAT_ADDR = 12'h044;
  localparam logic [11:0] DSD_INT_MASK_ADDR = 12'h048;
  localparam logic [11:0] DSD_CODE_ADDR = 12'h04c;
  localparam logic [11:0] DSD_DISP_ADDR = 12'h050;
  localparam logic [31:0] DSD_ZERO32 = 32'h0000_0000;

  // ==========================================================
  // state word bit positions
  localparam int DSD_B_RELEASED = 0;
  localparam int DSD_B_ZERO_CMD = 1;
  localparam int DSD_B_SW_PLUS = 2;
  localparam int DSD_B_SW_MINUS = 3;
  localparam int DSD_B_ICNS = 5;
  localparam int DSD_B_MODE_PI = 6;
  localparam int DSD_B_MODE_PN = 7;
  localparam int DSD_B_MODE_SPD = 8;
  localparam int DSD_B_LOW_SPEED = 9;
  localparam int DSD_B_REF_IN = 10;
  localparam int DSD_B_HOMING = 11;
  localparam int DSD_B_HOMED = 12;
  localparam int DSD_B_IN_TOL = 13;
  localparam int DSD_B_READY = 14;
  localparam int DSD_B_BRAKE = 15;
  localparam int DSD_B_NCLIP_P = 16;
  localparam int DSD_B_NCLIP_N = 17;
  localparam int DSD_B_NCLIP = 18;
  localparam int DSD_B_ICLIP = 19;
  localparam int DSD_B_IRED = 20;
  localparam int DSD_B_ILIM = 21;

  // ==========================================================
  // interrupt status bits
  localparam int DSD_IRQ_W = 4;
  localparam int DSD_I_FAULT = 0;
  localparam int DSD_I_WARN = 1;
  localparam int DSD_I_CMD = 2;
  localparam int DSD_I_RELEASE = 3;

  // ==========================================================
  // warning numbers
  localparam logic [3:0] DSD_WARN_MOTOR_TEMP = 4'h1;
  localparam logic [3:0] DSD_WARN_DEV_TEMP = 4'h2;
  localparam logic [3:0] DSD_WARN_I2T = 4'h3;
  localparam logic [3:0] DSD_WARN_DISABLED = 4'h4;
  localparam logic [3:0] DSD_WARN_NONE = 4'h0;

  // ==========================================================
  // timing
  localparam int DSD_CLK_HZ = 50_000_000;
  localparam int DSD_CMD_MS = 100;
  localparam int DSD_CMD_CYC = DSD_CLK_HZ / 1000 * DSD_CMD_MS;
  localparam int DSD_BLINK_MS = 250;
  localparam int DSD_BLINK_CYC = DSD_CLK_HZ / 1000 * DSD_BLINK_MS;
  localparam int DSD_WARN_MS = 1000;
  localparam int DSD_WARN_CYC = DSD_CLK_HZ / 1000 * DSD_WARN_MS;

  // seven-segment positions of the indicator segments
  localparam int DSD_SEG_CW = 1;
  localparam int DSD_SEG_CCW = 5;
  localparam int DSD_SEG_CURRENT = 4;
  localparam int DSD_SEG_ENABLE = 3;
  localparam int DSD_SEG_STILL = 6;
  localparam int DSD_SEG_CMD = 0;

  // ==========================================================
  // display mode
  typedef enum logic [1:0] {
    DSD_M_NORMAL = 2'b00,
    DSD_M_WARN = 2'b01,
    DSD_M_FAULT = 2'b11
  } dsd_mode_t;

  // ==========================================================
  // drive condition carrier
  typedef struct packed {
    logic released;
    logic speed_cmd_zero;
    logic sw_plus;
    logic sw_minus;
    logic icns;
    logic i_max;
    logic mode_pi;
    logic mode_pn;
    logic mode_spd;
    logic speed_pos;
    logic speed_neg;
    logic low_speed;
    logic ref_in;
    logic homing;
    logic homed;
    logic in_tol;
    logic brake;
    logic nclip_p;
    logic nclip_n;
    logic nclip;
    logic iclip;
    logic ired;
    logic ilim;
  } dsd_cond_t;

  typedef struct packed {
    logic motor_temp;
    logic dev_temp;
    logic i2t;
    logic cpu_alive;
    logic aux_ok;
    logic hw_fail;
    logic fault;
  } dsd_health_t;

  // ==========================================================
  // seven-segment glyphs for 0..f
  function automatic logic [6:0] dsd_glyph(input logic [3:0] v);
    case (v)
      4'h0: dsd_glyph = 7'h3f;
      4'h1: dsd_glyph = 7'h06;
      4'h2: dsd_glyph = 7'h5b;
      4'h3: dsd_glyph = 7'h4f;
      4'h4: dsd_glyph = 7'h66;
      4'h5: dsd_glyph = 7'h6d;
      4'h6: dsd_glyph = 7'h7d;
      4'h7: dsd_glyph = 7'h07;
      4'h8: dsd_glyph = 7'h7f;
      4'h9: dsd_glyph = 7'h6f;
      4'ha: dsd_glyph = 7'h77;
      4'hb: dsd_glyph = 7'h7c;
      4'hc: dsd_glyph = 7'h39;
      4'hd: dsd_glyph = 7'h5e;
      4'he: dsd_glyph = 7'h79;
      default: dsd_glyph = 7'h71;
    endcase
  endfunction

endpackage

/* src/dsd_top.sv */
// module: drive state word, front-panel indicators and apb register slave
//
// The implementer's own choice: the APB slave port.
`timescale 1ns/100ps

module dsd_top
  import dsd_pkg::*;
#(
  parameter int CMD_CYC = DSD_CMD_CYC,
  parameter int BLINK_CYC = DSD_BLINK_CYC,
  parameter int WARN_CYC = DSD_WARN_CYC
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire dsd_cond_t cond_in,
  input wire dsd_health_t health_in,
  input wire logic [3:0] error_no,
  input wire logic cmd_strobe,
  output logic irq,
  output logic ready_relay,
  output logic red_led,
  output logic green_en,
  output logic [6:0] seg,
  output logic seg_dp,
  output logic [3:0] warn_code,
  output logic startup_done,
  output logic standstill_flag
);

  // ==========================================================
  // input synchronisers
  dsd_cond_t cond_s1_r, cond_r;
  dsd_health_t hlth_s1_r, hlth_r;
  logic [3:0] err_s1_r, err_r;
  logic cmd_s1_r, cmd_s2_r, cmd_s3_r;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cond_s1_r <= '0;
      cond_r <= '0;
    end else begin
      cond_s1_r <= cond_in;
      cond_r <= cond_s1_r;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      hlth_s1_r <= '0;
      hlth_r <= '0;
    end else begin
      hlth_s1_r <= health_in;
      hlth_r <= hlth_s1_r;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      err_s1_r <= 4'h0;
      err_r <= 4'h0;
    end else begin
      err_s1_r <= error_no;
      err_r <= err_s1_r;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cmd_s1_r <= 1'b0;
      cmd_s2_r <= 1'b0;
      cmd_s3_r <= 1'b0;
    end else begin
      cmd_s1_r <= cmd_strobe;
      cmd_s2_r <= cmd_s1_r;
      cmd_s3_r <= cmd_s2_r;
    end
  end

  logic cmd_evt;
  assign cmd_evt = cmd_s2_r & ~cmd_s3_r;

  // ==========================================================
  // blink and timers
  logic [31:0] blink_cnt_r, warn_cnt_r, cmd_cnt_r;
  logic blink_r, warn_phase_r;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      blink_cnt_r <= DSD_ZERO32;
      blink_r <= 1'b0;
    end else if (blink_cnt_r >= 32'(BLINK_CYC - 1)) begin
      blink_cnt_r <= DSD_ZERO32;
      blink_r <= ~blink_r;
    end else begin
      blink_cnt_r <= blink_cnt_r + 32'h1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      warn_cnt_r <= DSD_ZERO32;
      warn_phase_r <= 1'b0;
    end else if (warn_cnt_r >= 32'(WARN_CYC - 1)) begin
      warn_cnt_r <= DSD_ZERO32;
      warn_phase_r <= ~warn_phase_r;
    end else begin
      warn_cnt_r <= warn_cnt_r + 32'h1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cmd_cnt_r <= DSD_ZERO32;
    end else if (cmd_evt) begin
      cmd_cnt_r <= 32'(CMD_CYC);
    end else if (cmd_cnt_r != DSD_ZERO32) begin
      cmd_cnt_r <= cmd_cnt_r - 32'h1;
    end
  end

  // ==========================================================
  // warnings and mode
  logic [3:0] warn_nxt;
  dsd_mode_t mode;

  function automatic logic warn_active(input logic [3:0] w);
    warn_active = (w != DSD_WARN_NONE);
  endfunction

  always_comb begin
    if (hlth_r.motor_temp) begin
      warn_nxt = DSD_WARN_MOTOR_TEMP;
    end else if (hlth_r.dev_temp) begin
      warn_nxt = DSD_WARN_DEV_TEMP;
    end else if (hlth_r.i2t) begin
      warn_nxt = DSD_WARN_I2T;
    end else if (!cond_r.released) begin
      warn_nxt = DSD_WARN_DISABLED;
    end else begin
      warn_nxt = DSD_WARN_NONE;
    end
  end

  always_comb begin
    if (hlth_r.fault) begin
      mode = DSD_M_FAULT;
    end else if (warn_active(warn_nxt)) begin
      mode = DSD_M_WARN;
    end else begin
      mode = DSD_M_NORMAL;
    end
  end

  // ==========================================================
  // startup flag
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      startup_done <= 1'b0;
    end else if (cond_r.released) begin
      startup_done <= 1'b1;
    end
  end

  // ==========================================================
  // state word
  logic [31:0] state_nxt, state_r;

  always_comb begin
    state_nxt = DSD_ZERO32;
    state_nxt[DSD_B_RELEASED] = cond_r.released;
    state_nxt[DSD_B_ZERO_CMD] = cond_r.speed_cmd_zero;
    state_nxt[DSD_B_SW_PLUS] = cond_r.sw_plus;
    state_nxt[DSD_B_SW_MINUS] = cond_r.sw_minus;
    state_nxt[DSD_B_ICNS] = cond_r.icns;
    state_nxt[DSD_B_MODE_PI] = cond_r.mode_pi;
    state_nxt[DSD_B_MODE_PN] = cond_r.mode_pn;
    state_nxt[DSD_B_MODE_SPD] = cond_r.mode_spd;
    state_nxt[DSD_B_LOW_SPEED] = cond_r.low_speed;
    state_nxt[DSD_B_REF_IN] = cond_r.ref_in;
    state_nxt[DSD_B_HOMING] = cond_r.homing;
    state_nxt[DSD_B_HOMED] = cond_r.homed;
    state_nxt[DSD_B_IN_TOL] = cond_r.in_tol;
    state_nxt[DSD_B_READY] = ~hlth_r.fault;
    state_nxt[DSD_B_BRAKE] = cond_r.brake;
    state_nxt[DSD_B_NCLIP_P] = cond_r.nclip_p;
    state_nxt[DSD_B_NCLIP_N] = cond_r.nclip_n;
    state_nxt[DSD_B_NCLIP] = cond_r.nclip;
    state_nxt[DSD_B_ICLIP] = cond_r.iclip;
    state_nxt[DSD_B_IRED] = cond_r.ired;
    state_nxt[DSD_B_ILIM] = cond_r.ilim;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_r <= DSD_ZERO32;
      ready_relay <= 1'b0;
    end else begin
      state_r <= state_nxt;
      ready_relay <= ~hlth_r.fault;
    end
  end

  // ==========================================================
  // front-panel drive
  logic [6:0] seg_nxt;
  logic [6:0] state_seg;
  logic still;

  assign still = ~cond_r.speed_pos & ~cond_r.speed_neg;

  always_comb begin
    state_seg = 7'h00;
    state_seg[DSD_SEG_ENABLE] = startup_done ? cond_r.released : blink_r;
    state_seg[DSD_SEG_STILL] = still;
    state_seg[DSD_SEG_CW] = cond_r.speed_pos;
    state_seg[DSD_SEG_CCW] = cond_r.speed_neg;
    state_seg[DSD_SEG_CURRENT] = cond_r.icns ? blink_r : cond_r.i_max;
    state_seg[DSD_SEG_CMD] = (cmd_cnt_r != DSD_ZERO32);
  end

  always_comb begin
    case (mode)
      DSD_M_FAULT: seg_nxt = dsd_glyph(err_r);
      DSD_M_WARN: seg_nxt = warn_phase_r ? dsd_glyph(warn_nxt) : state_seg;
      default: seg_nxt = state_seg;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      seg <= 7'h00;
    end else begin
      seg <= seg_nxt;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      seg_dp <= 1'b0;
    end else begin
      seg_dp <= hlth_r.cpu_alive & hlth_r.aux_ok & ~hlth_r.hw_fail & blink_r;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      red_led <= 1'b0;
      green_en <= 1'b0;
    end else begin
      red_led <= (mode == DSD_M_FAULT) | ((mode == DSD_M_WARN) & warn_phase_r);
      green_en <= (mode != DSD_M_FAULT);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      warn_code <= 4'h0;
    end else begin
      warn_code <= warn_nxt;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      standstill_flag <= 1'b0;
    end else begin
      standstill_flag <= still;
    end
  end

  // ==========================================================
  // interrupts
  logic [DSD_IRQ_W-1:0] ist_r, imask_r, ievt;
  logic fault_d_r, warn_d_r, rel_d_r;
  logic rd_en, wr_en;

  assign rd_en = psel & penable & ~pwrite;
  assign wr_en = psel & penable & pwrite;

  always_comb begin
    ievt = '0;
    ievt[DSD_I_FAULT] = hlth_r.fault & ~fault_d_r;
    ievt[DSD_I_WARN] = warn_active(warn_nxt) & ~warn_d_r;
    ievt[DSD_I_CMD] = cmd_evt;
    ievt[DSD_I_RELEASE] = cond_r.released & ~rel_d_r;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fault_d_r <= 1'b0;
      warn_d_r <= 1'b0;
      rel_d_r <= 1'b0;
    end else begin
      fault_d_r <= hlth_r.fault;
      warn_d_r <= warn_active(warn_nxt);
      rel_d_r <= cond_r.released;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ist_r <= '0;
    end else if (rd_en && paddr == DSD_INT_STAT_ADDR) begin
      ist_r <= ievt;
    end else begin
      ist_r <= ist_r | ievt;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      imask_r <= '0;
    end else if (wr_en && paddr == DSD_INT_MASK_ADDR) begin
      imask_r <= pwdata[DSD_IRQ_W-1:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq <= 1'b0;
    end else begin
      irq <= |(ist_r & imask_r);
    end
  end

  // ==========================================================
  // apb slave: zero wait states, unmapped addresses give pslverr
  logic [31:0] rd_nxt;
  logic err_nxt;

  always_comb begin
    rd_nxt = DSD_ZERO32;
    err_nxt = 1'b0;
    if (paddr == DSD_STATE_WORD_ADDR) begin
      rd_nxt = state_r;
      err_nxt = pwrite;
    end else if (paddr == DSD_INT_STAT_ADDR) begin
      rd_nxt = {{(32-DSD_IRQ_W){1'b0}}, ist_r};
      err_nxt = pwrite;
    end else if (paddr == DSD_INT_MASK_ADDR) begin
      rd_nxt = {{(32-DSD_IRQ_W){1'b0}}, imask_r};
    end else if (paddr == DSD_CODE_ADDR) begin
      rd_nxt = {24'h000000, warn_nxt, err_r};
      err_nxt = pwrite;
    end else if (paddr == DSD_DISP_ADDR) begin
      rd_nxt = {20'h00000, startup_done, ready_relay, red_led, green_en, seg_dp, seg};
      err_nxt = pwrite;
    end else begin
      err_nxt = 1'b1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= DSD_ZERO32;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready <= psel & ~penable;
      pslverr <= psel & ~penable & err_nxt;
      prdata <= (psel & ~penable & ~pwrite) ? rd_nxt : DSD_ZERO32;
    end
  end

endmodule

/* bench/dsd_monitor.sv */
// checker: port assertions of the drive status display
`timescale 1ns/100ps
module dsd_monitor
  import dsd_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire dsd_cond_t cond_in,
  input wire dsd_health_t health_in,
  input wire logic ready_relay,
  input wire logic red_led,
  input wire logic green_en,
  input wire logic [6:0] seg,
  input wire logic seg_dp,
  input wire logic [3:0] warn_code,
  input wire logic startup_done,
  input wire logic standstill_flag
);
  // ==========================================
  // properties
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  property p_word_gaps;
    psel && penable && pready && !pwrite && paddr == DSD_STATE_WORD_ADDR
      |-> prdata[31:22] == 10'h000 && !prdata[4];
  endproperty
  a_word_gaps: assert property (p_word_gaps) else $error("unused word bits set");
  property p_relay;
    health_in.fault [*5] |-> !ready_relay;
  endproperty
  a_relay: assert property (p_relay) else $error("relay closed in fault");
  property p_fault;
    health_in.fault [*5] |-> red_led && !green_en;
  endproperty
  a_fault: assert property (p_fault) else $error("fault lamp wrong");
  property p_start;
    startup_done |=> startup_done;
  endproperty
  a_start: assert property (p_start) else $error("startup flag fell");
  property p_start_set;
    cond_in.released [*5] |-> startup_done;
  endproperty
  a_start_set: assert property (p_start_set) else $error("startup flag not set");
  property p_still;
    (!cond_in.speed_pos && !cond_in.speed_neg) [*5] |-> standstill_flag;
  endproperty
  a_still: assert property (p_still) else $error("standstill flag low");
  property p_move;
    (cond_in.speed_pos ^ cond_in.speed_neg) [*5] |-> !standstill_flag;
  endproperty
  a_move: assert property (p_move) else $error("standstill flag high");
  property p_dp;
    (!health_in.aux_ok || health_in.hw_fail) [*5] |-> !seg_dp;
  endproperty
  a_dp: assert property (p_dp) else $error("decimal point lit without supply");
  property p_warn1;
    (health_in.motor_temp && !health_in.fault) [*5] |-> warn_code == DSD_WARN_MOTOR_TEMP;
  endproperty
  a_warn1: assert property (p_warn1) else $error("motor warning code");
  c_fault: cover property (health_in.fault && red_led);
  c_warn: cover property (warn_code != 4'h0 && red_led);
  c_cmd: cover property (seg[DSD_SEG_CMD] && !health_in.fault);
endmodule
bind dsd_top dsd_monitor dsd_monitor_inst (.pclk, .presetn, .psel, .penable, .pwrite,
  .paddr, .prdata, .pready, .cond_in, .health_in, .ready_relay, .red_led, .green_en,
  .seg, .seg_dp, .warn_code, .startup_done, .standstill_flag);

/* bench/dsd_panel_model.sv */
// partner: front panel that watches the lamps and counts blinks
`timescale 1ns/100ps
module dsd_panel_model (
  input wire logic pclk,
  input wire logic clr,
  input wire logic red_led,
  input wire logic seg_dp,
  input wire logic [6:0] seg,
  output int red_flips,
  output int dp_flips,
  output int cmd_on
);
  logic red_q;
  logic dp_q;
  // ==========================================
  // lamp edges and lit time of the command segment
  always @(posedge pclk) begin
    red_q <= red_led;
    dp_q <= seg_dp;
    if (clr) begin
      red_flips <= 0;
      dp_flips <= 0;
      cmd_on <= 0;
    end else begin
      red_flips <= red_flips + int'(red_led !== red_q);
      dp_flips <= dp_flips + int'(seg_dp !== dp_q);
      cmd_on <= cmd_on + int'(seg[0] === 1'b1);
    end
  end
endmodule

/* bench/tb_top.sv */
// testbench: apb reads, panel behaviour and interrupts of dsd_top
`timescale 1ns/100ps
module tb_top;
  import dsd_pkg::*;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0000_0000;
  dsd_cond_t cond = '0;
  dsd_health_t hlth = 7'h0c;
  logic [3:0] err_no = 4'h0;
  logic strobe = 1'b0;
  logic clr = 1'b0;
  logic [31:0] prdata, q;
  logic pready, pslverr, e, irq, relay, red, green, dp, sdone, still;
  logic [6:0] seg;
  logic [3:0] wcode;
  logic [6:0] m;
  localparam logic [6:0] SEG_GLYPH [16] = '{7'h3f, 7'h06, 7'h5b, 7'h4f, 7'h66, 7'h6d, 7'h7d,
    7'h07, 7'h7f, 7'h6f, 7'h77, 7'h7c, 7'h39, 7'h5e, 7'h79, 7'h71};
  int red_flips, dp_flips, cmd_on;
  int n_errors = 0;
  int n_compared = 0;
  dsd_top #(.CMD_CYC(8), .BLINK_CYC(4), .WARN_CYC(16)) dsd_top_inst (.pclk(pclk),
    .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .cond_in(cond),
    .health_in(hlth), .error_no(err_no), .cmd_strobe(strobe), .irq(irq),
    .ready_relay(relay), .red_led(red), .green_en(green), .seg(seg), .seg_dp(dp),
    .warn_code(wcode), .startup_done(sdone), .standstill_flag(still));
  dsd_panel_model dsd_panel_model_inst (.pclk(pclk), .clr(clr), .red_led(red),
    .seg_dp(dp), .seg(seg), .red_flips(red_flips), .dp_flips(dp_flips), .cmd_on(cmd_on));
  always #10 pclk = ~pclk;
  // ==========================================
  // helpers
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      n_errors++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge pclk);
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  function automatic logic [31:0] exp_word(input dsd_cond_t c, input logic f);
    exp_word = {10'h000, c.ilim, c.ired, c.iclip, c.nclip, c.nclip_n, c.nclip_p, c.brake,
      !f, c.in_tol, c.homed, c.homing, c.ref_in, c.low_speed, c.mode_spd, c.mode_pn,
      c.mode_pi, c.icns, 1'b0, c.sw_minus, c.sw_plus, c.speed_cmd_zero, c.released};
  endfunction
  function automatic logic [6:0] exp_seg(input dsd_cond_t c);
    exp_seg = 7'h00;
    exp_seg[DSD_SEG_STILL] = !c.speed_pos && !c.speed_neg;
    exp_seg[DSD_SEG_CW] = c.speed_pos;
    exp_seg[DSD_SEG_CCW] = c.speed_neg;
    exp_seg[DSD_SEG_ENABLE] = c.released;
    exp_seg[DSD_SEG_CURRENT] = c.i_max;
  endfunction
  task automatic print_verdict();
    if (n_errors == 0 && n_compared > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  // ==========================================
  // tests
  initial begin
    void'($urandom(31));
    cyc(16);
    presetn <= 1'b1;
    cyc(6);
    chk({31'h0, sdone}, 32'h0);
    apb(1'b0, DSD_STATE_WORD_ADDR, 32'h0);
    chk(q, 32'h0000_4000);
    for (int i = 0; i < 24; i++) begin
      cond <= (i == 0) ? '1 : dsd_cond_t'(23'($urandom));
      hlth.fault <= i[0];
      err_no <= 4'($urandom);
      cyc(6);
      apb(1'b0, DSD_STATE_WORD_ADDR, 32'h0);
      chk(q, exp_word(cond, hlth.fault));
      chk({31'h0, relay}, {31'h0, !hlth.fault});
      chk({31'h0, green}, {31'h0, !hlth.fault});
      chk({31'h0, still}, {31'h0, !cond.speed_pos && !cond.speed_neg});
      m = 7'h7f;
      m[DSD_SEG_CURRENT] = !cond.icns;
      if (hlth.fault) chk({30'h0, red, green}, 32'h2);
      if (hlth.fault) chk({25'h0, seg}, {25'h0, SEG_GLYPH[err_no]});
      else if (cond.released) chk({25'h0, seg & m}, {25'h0, exp_seg(cond) & m});
    end
    apb(1'b1, DSD_STATE_WORD_ADDR, 32'hffff_ffff);
    chk({31'h0, e}, 32'h1);
    apb(1'b0, 12'h0fc, 32'h0);
    chk(q, 32'h0);
    chk({31'h0, e}, 32'h1);
    for (int k = 0; k < 5; k++) begin
      cond <= dsd_cond_t'({k != 3, 22'h0});
      hlth <= (k == 4) ? 7'h18 : 7'h0c | ((7'h40 >> k) & 7'h70);
      clr <= 1'b1;
      cyc(6);
      clr <= 1'b0;
      cyc(60);
      if (k < 4) chk({28'h0, wcode}, 32'(k + 1));
      if (k < 4) chk(32'(red_flips > 1), 32'h1);
      if (k < 4) begin
        while (red !== 1'b1) cyc(1);
        chk({25'h0, seg}, {25'h0, SEG_GLYPH[k + 1]});
      end
      chk(32'(dp_flips > 2), 32'(k < 4));
    end
    chk({31'h0, sdone}, 32'h1);
    hlth <= 7'h0c;
    cond <= dsd_cond_t'({1'b1, 22'h0});
    cyc(6);
    clr <= 1'b1;
    cyc(1);
    clr <= 1'b0;
    strobe <= 1'b1;
    cyc(3);
    strobe <= 1'b0;
    cyc(30);
    chk(32'(cmd_on), 32'h8);
    apb(1'b1, DSD_INT_MASK_ADDR, 32'hf);
    apb(1'b0, DSD_INT_MASK_ADDR, 32'h0);
    chk(q, 32'hf);
    apb(1'b0, DSD_INT_STAT_ADDR, 32'h0);
    cyc(3);
    chk({31'h0, irq}, 32'h0);
    hlth <= 7'h0d;
    cyc(6);
    chk({31'h0, irq}, 32'h1);
    apb(1'b0, DSD_INT_STAT_ADDR, 32'h0);
    chk(q & 32'h1, 32'h1);
    apb(1'b0, DSD_INT_STAT_ADDR, 32'h0);
    chk(q & 32'h1, 32'h0);
    apb(1'b1, DSD_INT_MASK_ADDR, 32'h0);
    strobe <= 1'b1;
    cyc(3);
    strobe <= 1'b0;
    cyc(8);
    chk({31'h0, irq}, 32'h0);
    apb(1'b0, DSD_INT_STAT_ADDR, 32'h0);
    chk(q & 32'h4, 32'h4);
    presetn <= 1'b0;
    cyc(2);
    presetn <= 1'b1;
    cyc(1);
    chk({31'h0, sdone}, 32'h0);
    print_verdict();
  end
  initial begin
    repeat (20000) @(posedge pclk);
    n_errors++;
    print_verdict();
  end
endmodule
